// >>> logic/scct_decode.sv
// combinational decode of a selected l3 entry and page walker entry
`timescale 1ns/1ps
`default_nettype none
module scct_decode (
  // selected entries and request attributes
  scct_lookup_if.decode_side lk
);

  // ==========================================================================
  // skip gate: a set mask bit demands the matching address bit be zero
  function automatic logic skip_pass(input logic en, input logic [2:0] mask,
                                     input logic [2:0] addr_hi);
    skip_pass = !en || ((mask & addr_hi) == 3'h0);
  endfunction

  // ==========================================================================
  // l3 memory type and cacheability
  wire [1:0] fld_type = lk.l3_entry[scct_pkg::L3_TYPE_LSB +: 2];
  wire [2:0] fld_mask = lk.l3_entry[scct_pkg::L3_SCC_LSB +: 3];
  wire fld_esc = lk.l3_entry[scct_pkg::L3_ESC_BIT];
  // direct eu accesses take the data port's two bits when the field says so
  wire use_eu = lk.l3_eu_direct && (fld_type == scct_pkg::L3_TYPE_EU);
  wire l3_skip_ok = skip_pass(fld_esc, fld_mask, lk.l3_addr_hi);

  assign lk.l3_type = use_eu ? lk.l3_eu_type : fld_type;
  // only writeback caches; skip gate overrides it
  assign lk.l3_cache_ok = (lk.l3_type == scct_pkg::L3_TYPE_WB) && l3_skip_ok;

  // ==========================================================================
  // last-level skip gate from the page walker entry
  assign lk.pw_llc_ok = skip_pass(lk.pw_entry[scct_pkg::PW_ESC_BIT],
                                  lk.pw_entry[scct_pkg::PW_SCC_LSB +: 3], lk.pw_addr_hi);

endmodule
`default_nettype wire

// >>> logic/scct_lookup_if.sv
// carrier between the table store and the entry decoder
`timescale 1ns/1ps
`default_nettype none
interface scct_lookup_if;
  logic [5:0] l3_entry;
  logic [2:0] l3_addr_hi;
  logic l3_eu_direct;
  logic [1:0] l3_eu_type;
  logic [1:0] l3_type;
  logic l3_cache_ok;
  logic [16:0] pw_entry;
  logic [2:0] pw_addr_hi;
  logic pw_llc_ok;

  modport table_side (
    output l3_entry, l3_addr_hi, l3_eu_direct, l3_eu_type, pw_entry, pw_addr_hi,
    input l3_type, l3_cache_ok, pw_llc_ok
  );
  modport decode_side (
    input l3_entry, l3_addr_hi, l3_eu_direct, l3_eu_type, pw_entry, pw_addr_hi,
    output l3_type, l3_cache_ok, pw_llc_ok
  );
endinterface
`default_nettype wire

// >>> logic/scct_pkg.sv
// package of offsets, field layouts and reset values for the surface cache control tables
package scct_pkg;

  // ==========================================================================
  // table geometry
  localparam int unsigned IDX_W = 6;
  localparam int unsigned ENG_W = 3;
  localparam int unsigned ENTRIES = 64;
  localparam int unsigned ENGINES = 8;
  localparam int unsigned L3_ENTRY_W = 6;
  localparam int unsigned PW_ENTRY_W = 17;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [15:0] L3_TABLE_BASE = 16'hb020;
  localparam logic [15:0] L3_TABLE_LAST = 16'hb09f;
  localparam logic [15:0] PW_TABLE_BASE = 16'hc800;
  localparam logic [15:0] PW_TABLE_LAST = 16'hcfff;
  localparam logic [5:0] HW_COH_EVICT_IDX = 6'h3f;
  localparam logic [5:0] HW_TILED_IDX = 6'h3e;

  // ==========================================================================
  // l3 entry fields
  localparam int unsigned L3_ESC_BIT = 0;
  localparam int unsigned L3_SCC_LSB = 1;
  localparam int unsigned L3_TYPE_LSB = 4;
  localparam logic [1:0] L3_TYPE_EU = 2'h0;
  localparam logic [1:0] L3_TYPE_UC = 2'h1;
  localparam logic [1:0] L3_TYPE_RSV = 2'h2;
  localparam logic [1:0] L3_TYPE_WB = 2'h3;

  // ==========================================================================
  // page walker entry fields
  localparam int unsigned PW_OUTER_LSB = 0;
  localparam int unsigned PW_TARGET_LSB = 2;
  localparam int unsigned PW_AGE_LSB = 4;
  localparam int unsigned PW_NOALLOC_BIT = 6;
  localparam int unsigned PW_ESC_BIT = 7;
  localparam int unsigned PW_SCC_LSB = 8;
  localparam int unsigned PW_COS_LSB = 15;
  localparam logic [1:0] PW_AGE_RESET = 2'h3;

  // l3 reset value, pattern repeats every 16 indices
  function automatic logic [5:0] l3_default(input logic [5:0] idx);
    case (idx[3:0])
      4'h1: l3_default = 6'h10;
      4'h2, 4'h6, 4'ha: l3_default = 6'h13;
      4'h3, 4'h7, 4'hb: l3_default = 6'h17;
      4'h4, 4'h8, 4'hc: l3_default = 6'h1f;
      4'h5: l3_default = 6'h20;
      4'h9: l3_default = 6'h30;
      default: l3_default = 6'h00;
    endcase
  endfunction

  // page walker reset value: outer type and target cache, age mode 3
  function automatic logic [16:0] pw_default(input logic [5:0] idx);
    logic [3:0] tt;
    tt = 4'h0;
    case (idx[3:0])
      4'h1: tt = 4'h4;
      4'h2: tt = 4'h8;
      4'h3: tt = 4'h1;
      4'h4, 4'ha: tt = 4'h2;
      4'h5, 4'hb: tt = 4'h6;
      4'h6, 4'hc: tt = 4'ha;
      4'h7, 4'hd: tt = 4'h3;
      4'h8, 4'he: tt = 4'h7;
      4'h9, 4'hf: tt = 4'hb;
      default: tt = 4'h0;
    endcase
    pw_default = {11'h000, PW_AGE_RESET, tt};
  endfunction

endpackage

// >>> logic/scct_tables.sv
// surface cache control tables: l3 and page walker control entries behind apb
// Function
// - L3 holds sixty-four 16-bit control entries selected by the object control index.
// - the selected entry drives L3 caching for that surface; 64 distinct settings.
// - L3 table sits at B020 to B09F, 128 bytes, two 16-bit entries per word.
// - L3 type bits 5:4: 01 uncacheable, 11 writeback, 10 reserved, 00 eu only.
// - direct eu accesses combine the type field with two data-port bits.
// - skip mask bits 3:1 demand address bits 9, 10, 11 zero to cache.
// - bit 0 enables skip caching; cleared, the mask has no effect.
// - L3 reset values repeat every 16 indices in the fixed pattern.
// - page walker entries, 32-bit, give last-level and dram caching controls.
// - eight engine copies of 64 entries; each engine reads its own copy.
// - all entries are context state, saved and restored by the streamers.
// - page walker index 63 serves coherent evictions, 62 tiled-resource walks.
// - page walker table sits at C800 to CFFF, eight 256-byte blocks.
// - page walker bits 16:15 carry class of service; 31:17 reserved.
// - eu binding-table surfaces pass two memory-type bits to the walker.
// - bits 1:0 outer type: page table, uncacheable, write-through, writeback.
// - bits 3:2 target cache: page table, last-level only, or both caches.
// - bits 5:4 replacement age: default, age 0, keep on hit, age 3.
// - bit 6 set stops allocation on a target cache miss.
`timescale 1ns/1ps
`default_nettype none
module scct_tables #(
  parameter int unsigned ADDR_W = 16
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // l3 lookup request
  input wire logic L3_REQ,
  input wire logic [5:0] L3_INDEX,
  input wire logic [2:0] L3_ADDR_HI,
  input wire logic L3_EU_DIRECT,
  input wire logic [1:0] L3_EU_TYPE,
  // l3 lookup answer
  output logic L3_RSP_VALID,
  output logic [1:0] L3_MEM_TYPE,
  output logic L3_CACHE_OK,
  // page walker lookup request
  input wire logic PW_REQ,
  input wire logic [2:0] PW_ENGINE,
  input wire logic [5:0] PW_INDEX,
  input wire logic PW_COH_EVICT,
  input wire logic PW_TILED,
  input wire logic [2:0] PW_ADDR_HI,
  input wire logic PW_EU_BT,
  input wire logic [1:0] PW_EU_TYPE,
  // page walker lookup answer
  output logic PW_RSP_VALID,
  output logic [1:0] PW_OUTER_TYPE,
  output logic [1:0] PW_TARGET_CACHE,
  output logic [1:0] PW_AGE_MODE,
  output logic PW_NO_ALLOC,
  output logic [1:0] PW_CLASS_OF_SERVICE,
  output logic PW_LLC_SKIP_OK,
  output logic PW_EU_BT_OUT,
  output logic [1:0] PW_EU_TYPE_OUT
);

  // ==========================================================================
  // storage: only the defined bits are kept, so reserved bits cost nothing
  logic [5:0] l3_q [64];
  logic [16:0] pw_q [8][64];

  // ==========================================================================
  // apb address decode
  wire [15:0] addr16 = PADDR[15:0];
  wire l3_sel = (addr16 >= scct_pkg::L3_TABLE_BASE) &&
                (addr16 <= scct_pkg::L3_TABLE_LAST);
  wire pw_sel = (addr16 >= scct_pkg::PW_TABLE_BASE) &&
                (addr16 <= scct_pkg::PW_TABLE_LAST);
  wire [15:0] l3_off = addr16 - scct_pkg::L3_TABLE_BASE;
  wire [15:0] pw_off = addr16 - scct_pkg::PW_TABLE_BASE;
  // each l3 word packs two 16-bit entries: even index low half, odd index high
  wire [4:0] l3_word = l3_off[6:2];
  wire [5:0] l3_lo_idx = {l3_word, 1'b0};
  wire [5:0] l3_hi_idx = {l3_word, 1'b1};
  // one 256-byte block per engine, one word per entry
  wire [2:0] pw_eng = pw_off[10:8];
  wire [5:0] pw_idx = pw_off[7:2];
  wire mapped = l3_sel || pw_sel;
  wire setup = PSEL && !PENABLE;
  wire wr_commit = PSEL && PENABLE && PWRITE && PREADY && mapped;

  // ==========================================================================
  // read data mux, reserved bits forced to zero
  wire [31:0] l3_rd_word = {10'h000, l3_q[l3_hi_idx], 10'h000, l3_q[l3_lo_idx]};
  wire [31:0] pw_rd_word = {15'h0000, pw_q[pw_eng][pw_idx]};
  wire [31:0] rd_mux = l3_sel ? l3_rd_word : (pw_sel ? pw_rd_word : 32'h0000_0000);

  // ==========================================================================
  // write data, merged per byte lane into the kept bits only
  function automatic logic [16:0] pw_merge(input logic [16:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb);
    logic [16:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      m[15:8] = wd[15:8];
    end
    if (strb[2]) begin
      m[16] = wd[16];
    end
    pw_merge = m; // bits 31:17 dropped
  endfunction

  wire l3_wr_lo = wr_commit && l3_sel && PSTRB[0];
  wire l3_wr_hi = wr_commit && l3_sel && PSTRB[2];
  wire pw_wr = wr_commit && pw_sel;
  wire [16:0] pw_wr_val = pw_merge(pw_q[pw_eng][pw_idx], PWDATA, PSTRB);

  // ==========================================================================
  // apb answer: zero wait states, read data captured in the setup cycle
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q & PSEL & PENABLE;

  // read path also serves the streamers' context save and restore
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
      pslverr_q <= !mapped;
    end
  end

  // ==========================================================================
  // l3 table store; resets to the repeating default pattern
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 64; i++) begin
        l3_q[i] <= scct_pkg::l3_default(6'(i));
      end
    end else begin
      if (l3_wr_lo) begin
        l3_q[l3_lo_idx] <= PWDATA[5:0];
      end
      if (l3_wr_hi) begin
        l3_q[l3_hi_idx] <= PWDATA[21:16];
      end
    end
  end

  // ==========================================================================
  // page walker store, eight engine copies
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int e = 0; e < 8; e++) begin
        for (int i = 0; i < 64; i++) begin
          pw_q[e][i] <= scct_pkg::pw_default(6'(i));
        end
      end
    end else if (pw_wr) begin
      pw_q[pw_eng][pw_idx] <= pw_wr_val;
    end
  end

  // ==========================================================================
  // lookup selection; hardware-owned indices override the requester's
  wire [5:0] pw_look_idx = PW_COH_EVICT ? scct_pkg::HW_COH_EVICT_IDX :
                           (PW_TILED ? scct_pkg::HW_TILED_IDX : PW_INDEX);
  wire [16:0] pw_entry = pw_q[PW_ENGINE][pw_look_idx];
  wire [5:0] l3_entry = l3_q[L3_INDEX];

  scct_lookup_if lk ();

  assign lk.l3_entry = l3_entry;
  assign lk.l3_addr_hi = L3_ADDR_HI;
  assign lk.l3_eu_direct = L3_EU_DIRECT;
  assign lk.l3_eu_type = L3_EU_TYPE;
  assign lk.pw_entry = pw_entry;
  assign lk.pw_addr_hi = PW_ADDR_HI;

  // entry decode kept apart so both paths share the skip gate
  scct_decode u_decode (
    .lk(lk.decode_side)
  );

  // ==========================================================================
  // l3 answer registers, one cycle after the request
  logic l3_vld_q;
  logic [1:0] l3_type_q;
  logic l3_ok_q;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      l3_vld_q <= 1'b0;
      l3_type_q <= 2'h0;
      l3_ok_q <= 1'b0;
    end else begin
      l3_vld_q <= L3_REQ;
      if (L3_REQ) begin
        l3_type_q <= lk.l3_type;
        l3_ok_q <= lk.l3_cache_ok;
      end
    end
  end

  assign L3_RSP_VALID = l3_vld_q;
  assign L3_MEM_TYPE = l3_type_q;
  assign L3_CACHE_OK = l3_ok_q;

  // ==========================================================================
  // page walker answer registers, one cycle after the request
  logic pw_vld_q;
  logic [16:0] pw_ent_q;
  logic pw_llc_ok_q;
  logic pw_bt_q;
  logic [1:0] pw_eut_q;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pw_vld_q <= 1'b0;
      pw_ent_q <= 17'h00000;
      pw_llc_ok_q <= 1'b0;
      pw_bt_q <= 1'b0;
      pw_eut_q <= 2'h0;
    end else begin
      pw_vld_q <= PW_REQ;
      if (PW_REQ) begin
        pw_ent_q <= pw_entry;
        pw_llc_ok_q <= lk.pw_llc_ok;
        pw_bt_q <= PW_EU_BT;
        pw_eut_q <= PW_EU_BT ? PW_EU_TYPE : 2'h0;
      end
    end
  end

  // ==========================================================================
  // page walker field split; encodings pass to the caches unchanged
  assign PW_RSP_VALID = pw_vld_q;
  assign PW_OUTER_TYPE = pw_ent_q[scct_pkg::PW_OUTER_LSB +: 2];
  assign PW_TARGET_CACHE = pw_ent_q[scct_pkg::PW_TARGET_LSB +: 2];
  assign PW_AGE_MODE = pw_ent_q[scct_pkg::PW_AGE_LSB +: 2];
  assign PW_NO_ALLOC = pw_ent_q[scct_pkg::PW_NOALLOC_BIT];
  assign PW_CLASS_OF_SERVICE = pw_ent_q[scct_pkg::PW_COS_LSB +: 2];
  assign PW_LLC_SKIP_OK = pw_llc_ok_q;
  assign PW_EU_BT_OUT = pw_bt_q;
  assign PW_EU_TYPE_OUT = pw_eut_q;

endmodule
`default_nettype wire

// >>> tb/scct_requester.sv
// random lookup requester standing in for the l3 banks and walker engines
`timescale 1ns/1ps
`default_nettype none
module scct_requester (
  // clock, reset and enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // l3 lookup request
  output logic l3_req,
  output logic [5:0] l3_idx,
  output logic [2:0] l3_ahi,
  output logic l3_eu,
  output logic [1:0] l3_ty,
  // page walker lookup request
  output logic pw_req,
  output logic [2:0] pw_eng,
  output logic [5:0] pw_idx,
  output logic pw_coh,
  output logic pw_tiled,
  output logic [2:0] pw_ahi,
  output logic pw_bt,
  output logic [1:0] pw_ty
);
  // ==========================================================================
  // request source
  int seed = 52;
  logic [31:0] r;
  // fields churn every cycle, so a stale field never passes for a held one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {l3_req, l3_idx, l3_ahi, l3_eu, l3_ty} <= 13'h0;
      {pw_req, pw_eng, pw_idx, pw_coh, pw_tiled, pw_ahi, pw_bt, pw_ty} <= 18'h0;
    end else begin
      r = $random(seed);
      {l3_idx, l3_ahi, l3_eu, l3_ty} <= r[11:0];
      {pw_eng, pw_idx, pw_ahi, pw_bt, pw_ty} <= r[26:12];
      l3_req <= en & r[27];
      pw_req <= en & r[28];
      pw_coh <= r[29] & r[30];
      pw_tiled <= r[31] & r[30];
    end
  end
endmodule
`default_nettype wire

// >>> tb/scct_tables_assertions.sv
// concurrent checks on the cache control table ports
`timescale 1ns/1ps
`default_nettype none
module scct_tables_assertions #(
  parameter int unsigned ADDR_W = 16
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // lookups
  input wire logic L3_REQ,
  input wire logic L3_RSP_VALID,
  input wire logic [1:0] L3_MEM_TYPE,
  input wire logic L3_CACHE_OK,
  input wire logic PW_REQ,
  input wire logic PW_EU_BT,
  input wire logic [1:0] PW_EU_TYPE,
  input wire logic PW_RSP_VALID,
  input wire logic [1:0] PW_OUTER_TYPE,
  input wire logic PW_EU_BT_OUT,
  input wire logic [1:0] PW_EU_TYPE_OUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // address decode of the access phase
  wire logic acc = PSEL && PENABLE;
  wire logic rd = acc && !PWRITE;
  wire logic in_l3 = PADDR[15:0] >= 16'hb020 && PADDR[15:0] <= 16'hb09f;
  wire logic in_pw = PADDR[15:0] >= 16'hc800 && PADDR[15:0] <= 16'hcfff;
  // answers one cycle after each request, walker outer type held otherwise
  property p_l3_rsp; L3_RSP_VALID == $past(L3_REQ); endproperty
  a_l3_rsp: assert property (p_l3_rsp) else $error("l3 answer timing");
  property p_pw_rsp; PW_REQ |=> PW_RSP_VALID; endproperty
  a_pw_rsp: assert property (p_pw_rsp) else $error("walker answer missing");
  property p_pw_hold; !PW_REQ |=> !PW_RSP_VALID && $stable(PW_OUTER_TYPE); endproperty
  a_pw_hold: assert property (p_pw_hold) else $error("walker answer moved");
  property p_l3_ok; L3_RSP_VALID && L3_CACHE_OK |-> L3_MEM_TYPE == 2'h3; endproperty
  a_l3_ok: assert property (p_l3_ok) else $error("cacheable without writeback");
  property p_pw_eu;
    PW_REQ |=> PW_EU_BT_OUT == $past(PW_EU_BT)
      && PW_EU_TYPE_OUT == ($past(PW_EU_BT) ? $past(PW_EU_TYPE) : 2'h0);
  endproperty
  a_pw_eu: assert property (p_pw_eu) else $error("eu type bits not passed");
  // bus answers: zero wait, error only off the map
  property p_ready; acc |-> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("access not ready");
  property p_err; acc && !in_l3 && !in_pw |-> PSLVERR && (PWRITE || PRDATA == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped access accepted");
  property p_noerr; acc && (in_l3 || in_pw) |-> !PSLVERR; endproperty
  a_noerr: assert property (p_noerr) else $error("mapped access refused");
  property p_rsv_pw; rd && in_pw |-> PRDATA[31:17] == 15'h0; endproperty
  a_rsv_pw: assert property (p_rsv_pw) else $error("walker reserved bits set");
  property p_rsv_l3; rd && in_l3 |-> PRDATA[31:22] == 10'h0 && PRDATA[15:6] == 10'h0; endproperty
  a_rsv_l3: assert property (p_rsv_l3) else $error("l3 reserved bits set");
  // main scenarios
  c_l3_ok: cover property (L3_RSP_VALID && L3_CACHE_OK);
  c_err: cover property (acc && PSLVERR);
  c_pw_bt: cover property (PW_RSP_VALID && PW_EU_BT_OUT);
endmodule
bind scct_tables scct_tables_assertions #(.ADDR_W(ADDR_W)) u_chk (.REF_CLK(REF_CLK),
  .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .L3_REQ(L3_REQ),
  .L3_RSP_VALID(L3_RSP_VALID), .L3_MEM_TYPE(L3_MEM_TYPE), .L3_CACHE_OK(L3_CACHE_OK),
  .PW_REQ(PW_REQ), .PW_EU_BT(PW_EU_BT), .PW_EU_TYPE(PW_EU_TYPE), .PW_RSP_VALID(PW_RSP_VALID),
  .PW_OUTER_TYPE(PW_OUTER_TYPE), .PW_EU_BT_OUT(PW_EU_BT_OUT), .PW_EU_TYPE_OUT(PW_EU_TYPE_OUT));
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the cache control tables: apb access and random lookups
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================================
  // stimulus, shadows and counters
  localparam logic [127:0] L3_DEF = 128'h0000001f1713301f1713201f17131000;
  localparam logic [63:0] PW_DEF = 64'hb73a62b73a621840;
  localparam logic [15:0] BAD [4] = '{16'hb01c, 16'hb0a0, 16'hc7fc, 16'hd000};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic en = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  wire logic pready, pslverr, l3_req, l3_eu, l3_v, l3_ok, pw_req, pw_coh, pw_tl, pw_bt;
  wire logic pw_v, pw_na, pw_ok, pw_bto;
  wire logic [31:0] prdata;
  wire logic [5:0] l3_idx, pw_idx;
  wire logic [2:0] l3_ahi, pw_eng, pw_ahi;
  wire logic [1:0] l3_ty, l3_mt, pw_ty, pw_ot, pw_tc, pw_age, pw_cos, pw_tyo;
  logic [5:0] l3_sh [64];
  logic [16:0] pw_sh [8][64];
  logic [2:0] l3_exp = 3'h0;
  logic [12:0] pw_exp = 13'h0;
  logic l3_pend = 1'b0;
  logic pw_pend = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 52;
  // 25 mhz clock
  initial forever #20 clk = ~clk;
  scct_tables #(.ADDR_W(16)) DUT (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .L3_REQ(l3_req), .L3_INDEX(l3_idx),
    .L3_ADDR_HI(l3_ahi), .L3_EU_DIRECT(l3_eu), .L3_EU_TYPE(l3_ty), .L3_RSP_VALID(l3_v),
    .L3_MEM_TYPE(l3_mt), .L3_CACHE_OK(l3_ok), .PW_REQ(pw_req), .PW_ENGINE(pw_eng),
    .PW_INDEX(pw_idx), .PW_COH_EVICT(pw_coh), .PW_TILED(pw_tl), .PW_ADDR_HI(pw_ahi),
    .PW_EU_BT(pw_bt), .PW_EU_TYPE(pw_ty), .PW_RSP_VALID(pw_v), .PW_OUTER_TYPE(pw_ot),
    .PW_TARGET_CACHE(pw_tc), .PW_AGE_MODE(pw_age), .PW_NO_ALLOC(pw_na),
    .PW_CLASS_OF_SERVICE(pw_cos), .PW_LLC_SKIP_OK(pw_ok), .PW_EU_BT_OUT(pw_bto),
    .PW_EU_TYPE_OUT(pw_tyo));
  scct_requester u_req (.clk(clk), .nrst(nrst), .en(en), .l3_req(l3_req), .l3_idx(l3_idx),
    .l3_ahi(l3_ahi), .l3_eu(l3_eu), .l3_ty(l3_ty), .pw_req(pw_req), .pw_eng(pw_eng),
    .pw_idx(pw_idx), .pw_coh(pw_coh), .pw_tiled(pw_tl), .pw_ahi(pw_ahi), .pw_bt(pw_bt),
    .pw_ty(pw_ty));
  // expected {type, cacheable} of an l3 entry
  function automatic logic [2:0] l3_expect(input logic [5:0] e, input logic [2:0] a,
      input logic eu, input logic [1:0] ty);
    logic [1:0] t;
    t = (eu && e[5:4] == 2'h0) ? ty : e[5:4];
    return {t, t == 2'h3 && (!e[0] || (e[3:1] & a) == 3'h0)};
  endfunction
  // expected walker answer fields
  function automatic logic [12:0] pw_expect(input logic [16:0] e, input logic [2:0] a,
      input logic bt, input logic [1:0] ty);
    return {e[6:0], e[16:15], !e[7] || (e[10:8] & a) == 3'h0, bt, bt ? ty : 2'h0};
  endfunction
  // expected {error, read data} of a word
  function automatic logic [32:0] exp_rd(input logic [15:0] a);
    logic [15:0] o;
    o = a - 16'hb020;
    if (a >= 16'hb020 && a <= 16'hb09f)
      return {11'h0, l3_sh[{o[6:2], 1'b1}], 10'h0, l3_sh[{o[6:2], 1'b0}]};
    o = a - 16'hc800;
    if (a >= 16'hc800 && a <= 16'hcfff)
      return {16'h0, pw_sh[o[10:8]][o[7:2]]};
    return {1'b1, 32'h0};
  endfunction
  task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_lk(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t lookup got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the bus stays claimed so the next setup can follow at once
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
      output logic [32:0] r);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // hold the request until pready is seen high at a rising edge, take the answer there
    do @(posedge clk); while (pready !== 1'b1);
    r = {pslverr, prdata};
  endtask
  task automatic rd(input logic [15:0] a);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk_reg(r, exp_rd(a));
  endtask
  task automatic rd_all();
    for (int k = 0; k < 32; k++) rd(16'hb020 + 16'(4 * k));
    for (int k = 0; k < 512; k++) rd(16'hc800 + 16'(4 * k));
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // answer check one edge after each request; tables are quiet while lookups run
  always @(posedge clk) begin
    if (nrst) begin
      chk_lk({l3_v, 10'h0, l3_mt, l3_ok}, {l3_pend, 10'h0, l3_exp});
      chk_lk({pw_v, pw_na, pw_age, pw_tc, pw_ot, pw_cos, pw_ok, pw_bto, pw_tyo},
        {pw_pend, pw_exp});
      l3_pend <= l3_req;
      pw_pend <= pw_req;
      if (l3_req) l3_exp <= l3_expect(l3_sh[l3_idx], l3_ahi, l3_eu, l3_ty);
      if (pw_req) pw_exp <= pw_expect(pw_sh[pw_eng][pw_coh ? 6'h3f : (pw_tl ? 6'h3e : pw_idx)],
        pw_ahi, pw_bt, pw_ty);
    end
  end
  // main sequence: defaults, off-map words, random programming, lookups
  initial begin
    logic [32:0] r;
    logic [31:0] d;
    logic [15:0] a;
    int k;
    for (int i = 0; i < 64; i++) begin
      l3_sh[i] = L3_DEF[8 * (i % 16) +: 6];
      for (int e = 0; e < 8; e++) pw_sh[e][i] = {11'h0, 2'h3, PW_DEF[4 * (i % 16) +: 4]};
    end
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_all();
    foreach (BAD[i]) begin
      apb(1'b1, BAD[i], 32'hffffffff, r);
      rd(BAD[i]);
    end
    repeat (200) begin
      d = $random(seed);
      k = $unsigned($random(seed)) % 600;
      a = (k < 496) ? 16'hc800 + 16'(256 * (k / 62) + 4 * (k % 62))
                    : 16'hb020 + 16'(4 * ((k - 496) % 31));
      apb(1'b1, a, d, r);
      if (k < 496) pw_sh[k / 62][k % 62] = d[16:0];
      else begin
        l3_sh[2 * ((k - 496) % 31)] = d[5:0];
        l3_sh[2 * ((k - 496) % 31) + 1] = d[21:16];
      end
      rd(a);
    end
    rd_all();
    psel <= 1'b0;
    pen <= 1'b0;
    en <= 1'b1;
    repeat (3000) @(posedge clk);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    wrap_up();
  end
  // hang guard, well past the expected run length
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
